// ---- dv/rtms_engine_model.sv ----
// scan engine model: feeds capture bytes and collects the host byte stream
`timescale 1ns/10ps
module rtms_engine_model (
  input  wire logic       clk_sys,
  input  wire logic       capReady,
  input  wire logic       outValid,
  input  wire logic [7:0] outData,
  input  wire logic       outEnd,
  output logic            capValid,
  output logic      [7:0] capData,
  output logic            capIsIdent,
  output logic            capFirstTag,
  output logic            capLast
);
  logic [7:0] got[$];
  int         ends = 0;
  initial begin
    capValid = 1'b0;
    capData = 8'h00;
    capIsIdent = 1'b0;
    capFirstTag = 1'b0;
    capLast = 1'b0;
  end
  always @(posedge clk_sys) begin
    if (outValid === 1'b1) got.push_back(outData);
    if (outEnd === 1'b1) ends++;
  end
  // word is {identifier, first tag, byte}; valid stays up between bytes, so no double drive
  task automatic sendStr(input logic [9:0] w[$], output bit ok);
    int n;
    ok = 1;
    foreach (w[i]) begin
      n = 0;
      capValid <= 1'b1;
      capData <= w[i][7:0];
      capIsIdent <= w[i][9];
      capFirstTag <= w[i][8];
      capLast <= (i == w.size() - 1);
      do begin
        @(posedge clk_sys);
        n++;
      end while (capReady !== 1'b1 && n < 50);
      if (n >= 50) ok = 0;
    end
    capValid <= 1'b0;
    capLast <= 1'b0;
    // released data line must not look like a stale byte
    capData <= ~capData;
  endtask
endmodule // rtms_engine_model

// ---- dv/rtms_seq_bench.sv ----
// self-checking bench for the trigger, mode and scan-sequence controller
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin nTests++; if ((gt) !== (ex)) begin failCount++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module rtms_seq_bench;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        triggerPin = 1'b0;
  logic        serialAttachPin = 1'b0;
  logic        usbUnit = 1'b1;
  logic        linkSerialSetting = 1'b1;
  logic        cmdValid = 1'b0;
  logic        cmdIsWrite = 1'b0;
  logic        kbdMode, cmdReady, tagWriteEn, scanBarcode, scanTag;
  logic        capValid, capIsIdent, capFirstTag, capLast, capReady;
  logic [7:0]  capData, outData;
  logic        outValid, outEnd;
  int          failCount = 0;
  int          nTests = 0;
  int          endsSeen = 0;
  logic [31:0] rd;
  logic [7:0]  ex[$];
  logic [9:0]  w[$];
  bit          seen;
  always #25 clk_sys = ~clk_sys;
  rtms_seq rtms_seq_i (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .triggerPin, .serialAttachPin, .usbUnit,
    .linkSerialSetting, .kbdMode, .cmdValid, .cmdIsWrite, .cmdReady, .tagWriteEn,
    .scanBarcode, .scanTag, .capValid, .capData, .capIsIdent, .capFirstTag, .capLast,
    .capReady, .outValid, .outData, .outEnd);
  rtms_engine_model rtms_engine_model_i (.clk_sys, .capReady, .outValid, .outData, .outEnd,
    .capValid, .capData, .capIsIdent, .capFirstTag, .capLast);
  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wbXfer(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 20) begin
      failCount++;
      giveVerdict();
    end
  endtask
  task automatic doReset(input logic ser, input logic trig);
    rstn <= 1'b0;
    linkSerialSetting <= ser;
    triggerPin <= trig;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (12) @(posedge clk_sys);
  endtask
  // pull and wait for the engine enable of the expected event kind
  task automatic pull(input bit tag);
    int n;
    n = 0;
    @(posedge clk_sys);
    triggerPin <= 1'b1;
    while ((tag ? scanTag : scanBarcode) !== 1'b1 && n < 10) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("scan enable", 1'b1, n < 10)
    if (n >= 10) giveVerdict();
  endtask
  task automatic release_trig();
    @(posedge clk_sys);
    triggerPin <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic cmdWrite();
    seen = 0;
    @(posedge clk_sys);
    cmdValid <= 1'b1;
    cmdIsWrite <= 1'b1;
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    repeat (3) begin
      @(posedge clk_sys);
      if (tagWriteEn === 1'b1) seen = 1;
    end
  endtask
  task automatic sendExpect(input string nm);
    bit ok;
    int n;
    n = 0;
    rtms_engine_model_i.sendStr(w, ok);
    `CHK({nm, " taken"}, 1'b1, ok)
    if (!ok) giveVerdict();
    while (rtms_engine_model_i.ends == endsSeen && n < 30) begin
      @(posedge clk_sys);
      n++;
    end
    endsSeen = rtms_engine_model_i.ends;
    `CHK({nm, " end"}, 1'b1, n < 30)
    if (n >= 30) giveVerdict();
    `CHK({nm, " len"}, ex.size(), rtms_engine_model_i.got.size())
    foreach (ex[i]) begin
      if (i < rtms_engine_model_i.got.size()) `CHK(nm, ex[i], rtms_engine_model_i.got[i])
    end
    rtms_engine_model_i.got.delete();
  endtask
  initial begin
    doReset(1'b1, 1'b0);
    wbXfer(1'b0, 4'h0, 32'h0);
    `CHK("ctrl reset", 32'h0000_0230, rd)
    wbXfer(1'b0, 4'h4, 32'h0);
    `CHK("field reset", 32'h0, rd)
    wbXfer(1'b1, 4'hc, 32'hffff_ffff);
    wbXfer(1'b0, 4'hc, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    `CHK("serial mode", 1'b0, kbdMode)
    `CHK("cmd ready", 1'b1, cmdReady)
    cmdWrite();
    `CHK("tag write", 1'b1, seen)
    pull(1'b0);
    `CHK("no cmd in scan", 1'b0, cmdReady)
    cmdWrite();
    `CHK("no write in scan", 1'b0, seen)
    w = {10'h041, 10'h042};
    ex = {8'h41, 8'h42};
    sendExpect("barcode");
    repeat (10) @(posedge clk_sys);
    `CHK("held idle", 2'b00, {scanBarcode, scanTag})
    release_trig();
    pull(1'b1);
    w = {10'h355, 10'h143, 10'h100, 10'h144};
    ex = {8'h43};
    sendExpect("tag data");
    release_trig();
    pull(1'b0);
    release_trig();
    `CHK("abort silent", endsSeen, rtms_engine_model_i.ends)
    pull(1'b0);
    w = {};
    ex = {};
    for (int i = 0; i < 1030; i++) w.push_back(10'h061);
    for (int i = 0; i < 1024; i++) ex.push_back(8'h61);
    sendExpect("truncate");
    release_trig();
    wbXfer(1'b0, 4'h8, 32'h0);
    `CHK("status truncated", 32'h0000_0426, rd)
    wbXfer(1'b1, 4'h0, 32'h0000_0020);
    pull(1'b1);
    w = {10'h331, 10'h232, 10'h15a};
    ex = {8'h31};
    sendExpect("ident first");
    release_trig();
    wbXfer(1'b1, 4'h0, 32'h0000_0200);
    @(posedge clk_sys);
    triggerPin <= 1'b1;
    repeat (10) @(posedge clk_sys);
    `CHK("disabled", 2'b00, {scanBarcode, scanTag})
    release_trig();
    wbXfer(1'b1, 4'h0, 32'h0000_0310);
    wbXfer(1'b1, 4'h4, 32'h5d5b_0002);
    pull(1'b0);
    w = {10'h041, 10'h042, 10'h043};
    ex = {8'h5b, 8'h41, 8'h42, 8'h5d, 8'h5b, 8'h43, 8'h5d};
    sendExpect("field split");
    release_trig();
    doReset(1'b0, 1'b0);
    `CHK("kbd mode", 1'b1, kbdMode)
    `CHK("kbd no cmd", 1'b0, cmdReady)
    pull(1'b0);
    w = {10'h081, 10'h001, 10'h045, 10'h009, 10'h000, 10'h046};
    ex = {8'h45, 8'h09};
    sendExpect("kbd filter");
    release_trig();
    usbUnit <= 1'b0;
    serialAttachPin <= 1'b1;
    doReset(1'b0, 1'b0);
    `CHK("port cmd", 1'b1, cmdReady)
    usbUnit <= 1'b1;
    serialAttachPin <= 1'b0;
    doReset(1'b0, 1'b1);
    release_trig();
    `CHK("held swap serial", 1'b0, kbdMode)
    doReset(1'b1, 1'b1);
    release_trig();
    `CHK("held swap kbd", 1'b1, kbdMode)
    giveVerdict();
  end
endmodule // rtms_seq_bench

// ---- rtl/rtms_cfg.svh ----
// constants of the reader trigger and mode sequencer
// Summary of operation
// - USB power-on picks keyboard if setting keyboard idle, or serial setting held-then-released.
// - USB power-on picks serial if setting serial idle, or keyboard setting held-then-released.
// - trigger released means command mode, listening for host commands.
// - keyboard emulation never accepts commands; keyboard-port unit only through serial connector.
// - tag writes happen only in command mode.
// - trigger pull starts scanning at once, until read or trigger release.
// - captured strings are cut at 1024 bytes, excess bytes dropped.
// - disabled scan sequence disables trigger scanning.
// - scan sequence is one to three barcode or tag events, fourteen choices, default barcode-tag.
// - barcode style complete string or field split, one setting for all barcode events.
// - field split cuts string into fields wrapped by header and trailer characters.
// - tag style identifier, data, both or field split, for all tag events.
// - tag data bytes are sent up to the first NUL.
// - with several tags, only the first detected tag's identifier is read.
// - after a read, the next scan waits for release and a new pull.
// - keyboard emulation drops high-bit bytes and control bytes other than tab, LF, CR and ESC, and ends at NUL.
`ifndef RTMS_CFG_SVH
`define RTMS_CFG_SVH
`define RTMS_OFS_CTRL   4'h0
`define RTMS_OFS_FIELD  4'h4
`define RTMS_OFS_STATUS 4'h8
`define RTMS_CTRL_RST   32'h0000_0230
`define RTMS_FIELD_RST  32'h0000_0000
`define RTMS_SEQ_LSB    4
`define RTMS_BCFI_BIT   8
`define RTMS_FMT_LSB    9
`define RTMS_HDR_LSB    16
`define RTMS_TRL_LSB    24
`define RTMS_MAX_BYTES  11'h400
`define RTMS_BOOT_WAIT  2'h3
`endif

// ---- rtl/rtms_pkg.sv ----
// types of the reader trigger and mode sequencer
package rtms_pkg;
  typedef enum logic [2:0] {
    ST_BOOT, ST_BOOTWAIT, ST_CMD, ST_SCAN, ST_DONE, ST_HOLD
  } rtms_state_t;
  typedef enum logic [1:0] {
    FMT_IDENT, FMT_DATA, FMT_BOTH, FMT_FIELD
  } rtms_fmt_t;
endpackage

// ---- rtl/rtms_seq.sv ----
// trigger, mode and scan-sequence controller with wishbone registers
`timescale 1ns/10ps
`include "rtms_cfg.svh"
module rtms_seq (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        triggerPin,
  input  wire logic        serialAttachPin,
  input  wire logic        usbUnit,
  input  wire logic        linkSerialSetting,
  output logic             kbdMode,
  input  wire logic        cmdValid,
  input  wire logic        cmdIsWrite,
  output logic             cmdReady,
  output logic             tagWriteEn,
  output logic             scanBarcode,
  output logic             scanTag,
  input  wire logic        capValid,
  input  wire logic [7:0]  capData,
  input  wire logic        capIsIdent,
  input  wire logic        capFirstTag,
  input  wire logic        capLast,
  output logic             capReady,
  output logic             outValid,
  output logic      [7:0]  outData,
  output logic             outEnd
);

  logic                 rstMeta_q, rstSync_q;
  logic                 trgMeta_q, trg_q, serMeta_q, ser_q;
  rtms_pkg::rtms_state_t state_q, state_d;
  logic [1:0]           bootCnt_q;
  logic                 bootHeld_q;
  logic [31:0]          ctrl_q, field_q;
  logic [1:0]           seqPos_q;
  logic [10:0]          capCnt_q;
  logic [9:0]           fldCnt_q;
  logic                 dataStop_q, trunc_q;
  logic                 insHdr_q, insTrl_q, insHdr_d, insTrl_d;
  logic                 capReady_q, outValid_q, outEnd_q, kbdMode_q;
  logic [7:0]           outData_q;
  logic                 cmdReady_q, tagWrEn_q, scanBar_q, scanTag_q;
  logic                 ack_q;
  logic [31:0]          rdat_q;

  // decoded settings
  logic [3:0]           seqCode;
  logic [4:0]           seqInfo;
  logic [1:0]           seqLen;
  logic [2:0]           seqKinds;
  logic                 curTag, fieldOn, lastEv;
  rtms_pkg::rtms_fmt_t  tagFmt;
  logic [7:0]           hdrChr, trlChr;
  logic [9:0]           fldLen;
  logic                 capAcc, passFmt, printable, isNul, emit, fldEnd, busWr;

  // sequence table: {length, kinds}, kind 1 means tag event, event 0 in bit 0
  function automatic logic [4:0] decodeSeq(input logic [3:0] code);
    case (code)
      4'h1:    decodeSeq = {2'h1, 3'b000};
      4'h2:    decodeSeq = {2'h1, 3'b001};
      4'h3:    decodeSeq = {2'h2, 3'b010};
      4'h4:    decodeSeq = {2'h2, 3'b001};
      4'h5:    decodeSeq = {2'h2, 3'b000};
      4'h6:    decodeSeq = {2'h2, 3'b011};
      4'h7:    decodeSeq = {2'h3, 3'b000};
      4'h8:    decodeSeq = {2'h3, 3'b100};
      4'h9:    decodeSeq = {2'h3, 3'b010};
      4'ha:    decodeSeq = {2'h3, 3'b001};
      4'hb:    decodeSeq = {2'h3, 3'b110};
      4'hc:    decodeSeq = {2'h3, 3'b011};
      4'hd:    decodeSeq = {2'h3, 3'b101};
      4'he:    decodeSeq = {2'h3, 3'b111};
      default: decodeSeq = {2'h0, 3'b000};
    endcase
  endfunction

  assign seqCode  = ctrl_q[`RTMS_SEQ_LSB+3:`RTMS_SEQ_LSB];
  assign seqInfo  = decodeSeq(seqCode);
  assign seqLen   = seqInfo[4:3];
  assign seqKinds = seqInfo[2:0];
  assign curTag   = seqKinds[seqPos_q];
  assign tagFmt   = rtms_pkg::rtms_fmt_t'(ctrl_q[`RTMS_FMT_LSB+1:`RTMS_FMT_LSB]);
  assign hdrChr   = field_q[`RTMS_HDR_LSB+7:`RTMS_HDR_LSB];
  assign trlChr   = field_q[`RTMS_TRL_LSB+7:`RTMS_TRL_LSB];
  assign fldLen   = field_q[9:0];
  assign lastEv   = (seqPos_q == seqLen - 2'h1);
  // one style setting per source, shared by every event of that source
  assign fieldOn  = curTag ? (tagFmt == rtms_pkg::FMT_FIELD)
                           : ctrl_q[`RTMS_BCFI_BIT];

  // reset release and pin synchronisers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      trgMeta_q <= 1'b0;
      trg_q     <= 1'b0;
      serMeta_q <= 1'b0;
      ser_q     <= 1'b0;
    end else begin
      trgMeta_q <= triggerPin;
      trg_q     <= trgMeta_q;
      serMeta_q <= serialAttachPin;
      ser_q     <= serMeta_q;
    end
  end

  // capture path decisions
  assign capAcc    = capValid && capReady_q;
  assign isNul     = !capIsIdent && (capData == 8'h00);
  assign printable = !capData[7] && ((capData >= 8'h20 && capData != 8'h7f) ||
                     capData == 8'h09 || capData == 8'h0a ||
                     capData == 8'h0d || capData == 8'h1b);

  always_comb begin
    passFmt = 1'b1;
    if (curTag) begin
      case (tagFmt)
        rtms_pkg::FMT_IDENT: passFmt = capIsIdent;
        rtms_pkg::FMT_DATA:  passFmt = !capIsIdent;
        default:            passFmt = 1'b1;
      endcase
    end
  end

  // later tags' identifiers never reach the host
  assign emit = capAcc && passFmt && !(capIsIdent && !capFirstTag) &&
                !(dataStop_q && !capIsIdent) && !isNul &&
                (capCnt_q < `RTMS_MAX_BYTES) &&
                (!kbdMode_q || printable);
  assign fldEnd = emit && fieldOn && (fldLen != 10'h000) &&
                  (fldCnt_q == fldLen - 10'h001);

  // mode state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      rtms_pkg::ST_BOOT:
        if (bootCnt_q == `RTMS_BOOT_WAIT) begin
          state_d = (trg_q && usbUnit) ? rtms_pkg::ST_BOOTWAIT : rtms_pkg::ST_CMD;
        end
      rtms_pkg::ST_BOOTWAIT:
        if (!trg_q) begin
          state_d = rtms_pkg::ST_CMD;
        end
      rtms_pkg::ST_CMD:
        if (trg_q && seqLen != 2'h0) begin
          state_d = rtms_pkg::ST_SCAN;
        end
      rtms_pkg::ST_SCAN:
        if (!trg_q) begin
          state_d = rtms_pkg::ST_CMD;
        end else if (capAcc && capLast) begin
          state_d = rtms_pkg::ST_DONE;
        end
      rtms_pkg::ST_DONE:
        if (!insHdr_q && !insTrl_q) begin
          state_d = rtms_pkg::ST_HOLD;
        end
      rtms_pkg::ST_HOLD:
        if (!trg_q) begin
          state_d = rtms_pkg::ST_CMD;
        end
      default: state_d = rtms_pkg::ST_CMD;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q   <= rtms_pkg::ST_BOOT;
      bootCnt_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (state_q == rtms_pkg::ST_BOOT) begin
        bootCnt_q <= bootCnt_q + 2'h1;
      end
    end
  end

  // personality: setting as stored, inverted if trigger held through power-on on a USB unit
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      bootHeld_q <= 1'b0;
      kbdMode_q  <= 1'b0;
    end else if (state_q == rtms_pkg::ST_BOOT && state_d != rtms_pkg::ST_BOOT) begin
      bootHeld_q <= trg_q && usbUnit;
      kbdMode_q  <= !linkSerialSetting;
    end else if (state_q == rtms_pkg::ST_BOOTWAIT && !trg_q) begin
      kbdMode_q  <= linkSerialSetting;
    end
  end

  // sequence position, abort keeps it, last event wraps it
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      seqPos_q <= 2'h0;
    end else if (seqLen == 2'h0 || seqPos_q >= seqLen) begin
      seqPos_q <= 2'h0;
    end else if (state_q == rtms_pkg::ST_DONE && state_d == rtms_pkg::ST_HOLD) begin
      seqPos_q <= lastEv ? 2'h0 : seqPos_q + 2'h1;
    end
  end

  // per-scan counters and string termination
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      capCnt_q   <= 11'h000;
      fldCnt_q   <= 10'h000;
      dataStop_q <= 1'b0;
      trunc_q    <= 1'b0;
    end else if (state_q == rtms_pkg::ST_CMD && state_d == rtms_pkg::ST_SCAN) begin
      capCnt_q   <= 11'h000;
      fldCnt_q   <= 10'h000;
      dataStop_q <= 1'b0;
      trunc_q    <= 1'b0;
    end else if (capAcc) begin
      if (capCnt_q < `RTMS_MAX_BYTES) begin
        capCnt_q <= capCnt_q + 11'h001;
      end else begin
        trunc_q <= 1'b1;
      end
      if (isNul) begin
        dataStop_q <= 1'b1;
      end
      if (fldEnd) begin
        fldCnt_q <= 10'h000;
      end else if (emit && fieldOn) begin
        fldCnt_q <= fldCnt_q + 10'h001;
      end
    end
  end

  // header and trailer insertion; capture stalls while they go out
  always_comb begin
    insHdr_d = insHdr_q;
    insTrl_d = insTrl_q;
    if (insTrl_q) begin
      insTrl_d = 1'b0;
    end else if (insHdr_q) begin
      insHdr_d = 1'b0;
    end
    if (state_q == rtms_pkg::ST_CMD && state_d == rtms_pkg::ST_SCAN) begin
      insHdr_d = fieldOn && hdrChr != 8'h00;
      insTrl_d = 1'b0;
    end else if (state_q == rtms_pkg::ST_SCAN && !trg_q) begin
      insHdr_d = 1'b0;
      insTrl_d = 1'b0;
    end else if (fldEnd || (capAcc && capLast && fieldOn)) begin
      insTrl_d = trlChr != 8'h00;
      insHdr_d = !capLast && hdrChr != 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      insHdr_q   <= 1'b0;
      insTrl_q   <= 1'b0;
      capReady_q <= 1'b0;
    end else begin
      insHdr_q   <= insHdr_d;
      insTrl_q   <= insTrl_d;
      capReady_q <= state_d == rtms_pkg::ST_SCAN && trg_q && !insHdr_d && !insTrl_d &&
                    !(capAcc && capLast);
    end
  end

  // byte stream to the host link
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      outValid_q <= 1'b0;
      outData_q  <= 8'h00;
      outEnd_q   <= 1'b0;
    end else begin
      outValid_q <= 1'b0;
      outEnd_q   <= state_q == rtms_pkg::ST_DONE && state_d == rtms_pkg::ST_HOLD;
      if (insTrl_q) begin
        outValid_q <= 1'b1;
        outData_q  <= trlChr;
      end else if (insHdr_q) begin
        outValid_q <= 1'b1;
        outData_q  <= hdrChr;
      end else if (emit) begin
        outValid_q <= 1'b1;
        outData_q  <= capData;
      end
    end
  end

  // scan engines and command port
  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      scanBar_q  <= 1'b0;
      scanTag_q  <= 1'b0;
      cmdReady_q <= 1'b0;
      tagWrEn_q  <= 1'b0;
    end else begin
      scanBar_q  <= state_d == rtms_pkg::ST_SCAN && !curTag;
      scanTag_q  <= state_d == rtms_pkg::ST_SCAN && curTag;
      // commands only in command mode, and never over keyboard emulation
      // opens a cycle after entering, once the personality has settled
      cmdReady_q <= state_q == rtms_pkg::ST_CMD && state_d == rtms_pkg::ST_CMD &&
                    (!kbdMode_q || (!usbUnit && ser_q));
      tagWrEn_q  <= cmdValid && cmdReady_q && cmdIsWrite &&
                    state_q == rtms_pkg::ST_CMD;
    end
  end

  // wishbone slave, one wait state, writes land with the ack
  assign busWr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  always_ff @(posedge clk_sys or negedge rstSync_q) begin
    if (!rstSync_q) begin
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
      ctrl_q  <= `RTMS_CTRL_RST;
      field_q <= `RTMS_FIELD_RST;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      for (int i = 0; i < 4; i++) begin
        if (busWr && wb_sel_i[i] && wb_adr_i == `RTMS_OFS_CTRL) begin
          ctrl_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
        end
        if (busWr && wb_sel_i[i] && wb_adr_i == `RTMS_OFS_FIELD) begin
          field_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
        end
      end
      case (wb_adr_i)
        `RTMS_OFS_CTRL:   rdat_q <= ctrl_q;
        `RTMS_OFS_FIELD:  rdat_q <= field_q;
        `RTMS_OFS_STATUS: rdat_q <= {16'h0000, 5'h00, capCnt_q[10:0]} |
                                    {24'h000000, 1'b0, bootHeld_q, trunc_q,
                                     state_q == rtms_pkg::ST_SCAN, seqPos_q,
                                     state_q == rtms_pkg::ST_CMD, kbdMode_q} << 0;
        default:          rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = rdat_q;
  assign kbdMode     = kbdMode_q;
  assign cmdReady    = cmdReady_q;
  assign tagWriteEn  = tagWrEn_q;
  assign scanBarcode = scanBar_q;
  assign scanTag     = scanTag_q;
  assign capReady    = capReady_q;
  assign outValid    = outValid_q;
  assign outData     = outData_q;
  assign outEnd      = outEnd_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSync_q);

  a_tagwr_cmd_only: assert property (
    tagWriteEn |-> $past(state_q) == rtms_pkg::ST_CMD && $past(cmdValid))
    else $error("tag write outside command mode");
  a_kbd_no_cmd: assert property (
    cmdReady && kbdMode |-> !usbUnit)
    else $error("keyboard emulation accepting commands");
  a_cmd_on_release: assert property (
    state_q == rtms_pkg::ST_CMD && !trg_q && !kbdMode ##1 state_q == rtms_pkg::ST_CMD
    |-> cmdReady)
    else $error("command port closed in command mode");
  a_disabled_idle: assert property (
    state_q == rtms_pkg::ST_CMD && seqCode == 4'h0 |=> state_q != rtms_pkg::ST_SCAN)
    else $error("scan started with sequence disabled");
  a_pull_scans: assert property (
    state_q == rtms_pkg::ST_CMD && trg_q && seqLen != 2'h0
    |=> state_q == rtms_pkg::ST_SCAN ##0 (scanBarcode || scanTag))
    else $error("trigger pull did not start scan");
  a_abort_keep_pos: assert property (
    state_q == rtms_pkg::ST_SCAN && !trg_q
    |=> state_q == rtms_pkg::ST_CMD && $stable(seqPos_q) && !outEnd)
    else $error("abort changed position or ended event");
  a_trunc_limit: assert property (
    capAcc && capCnt_q >= `RTMS_MAX_BYTES |=> !outValid)
    else $error("byte beyond limit sent");
  a_nul_ends: assert property (
    capAcc && isNul |=> !outValid ##0 dataStop_q)
    else $error("nul byte not terminating");
  a_kbd_high_bit: assert property (
    capAcc && kbdMode && capData[7] |=> !outValid)
    else $error("high-bit byte sent in keyboard emulation");
  a_hold_release: assert property (
    state_q == rtms_pkg::ST_HOLD && trg_q |=> state_q == rtms_pkg::ST_HOLD [*1] ##0 !scanTag)
    else $error("rescan without trigger release");
  a_seq_wrap: assert property (
    state_q == rtms_pkg::ST_DONE && state_d == rtms_pkg::ST_HOLD && lastEv
    && seqLen != 2'h0 |=> seqPos_q == 2'h0 ##0 outEnd)
    else $error("sequence did not wrap after last event");

endmodule // rtms_seq
